// file: sclc_defs.vh
// Constants for the serial channel line configuration block.
`ifndef SCLC_DEFS_VH
`define SCLC_DEFS_VH

// Indirect register pointers.
`define SCLC_PTR_W        6
`define SCLC_PTR_META     6'h00
`define SCLC_PTR_RXCTL    6'h03
`define SCLC_PTR_MODELO   6'h04
`define SCLC_PTR_TXCTL    6'h05
`define SCLC_PTR_CMD_HI   5
`define SCLC_PTR_CMD_LO   4
`define SCLC_PTR_HI       5
`define SCLC_PTR_LO       0
`define SCLC_RESETA_HI    7
`define SCLC_RESETA_LO    6

// Receiver control fields.
`define SCLC_RX_WIDTH_HI  7
`define SCLC_RX_WIDTH_LO  6
`define SCLC_RX_AUTO      5
`define SCLC_RX_HUNT      4
`define SCLC_RX_CHECK     3
`define SCLC_RX_ADDR      2
`define SCLC_RX_MASK      1
`define SCLC_RX_ON        0

// Lower mode fields.
`define SCLC_MD_DIV_HI    7
`define SCLC_MD_DIV_LO    6
`define SCLC_MD_SYNC_HI   5
`define SCLC_MD_SYNC_LO   4
`define SCLC_MD_STOP_HI   3
`define SCLC_MD_STOP_LO   2
`define SCLC_MD_EVEN      1
`define SCLC_MD_PAR_ON    0

// Transmitter control fields.
`define SCLC_TX_DTR       7
`define SCLC_TX_WIDTH_HI  6
`define SCLC_TX_WIDTH_LO  5
`define SCLC_TX_BREAK     4
`define SCLC_TX_ON        3
`define SCLC_TX_POLY      2
`define SCLC_TX_RTS       1
`define SCLC_TX_CHECK     0

// Field codes.
`define SCLC_WIDTH_5      2'h0
`define SCLC_WIDTH_7      2'h1
`define SCLC_WIDTH_6      2'h2
`define SCLC_WIDTH_8      2'h3
`define SCLC_DIV_1        2'h0
`define SCLC_DIV_16       2'h1
`define SCLC_DIV_32       2'h2
`define SCLC_DIV_64       2'h3
`define SCLC_SYNC_SDLC    2'h2
`define SCLC_STOP_SYNC    2'h0
`define SCLC_STOP_1       2'h1
`define SCLC_STOP_1P5     2'h2
`define SCLC_STOP_2       2'h3

// Decoded values: bit counts, divide ratios, stop length in half bits, polynomials.
`define SCLC_BITS_5       4'h5
`define SCLC_BITS_6       4'h6
`define SCLC_BITS_7       4'h7
`define SCLC_BITS_8       4'h8
`define SCLC_RATIO_1      7'h01
`define SCLC_RATIO_16     7'h10
`define SCLC_RATIO_32     7'h20
`define SCLC_RATIO_64     7'h40
`define SCLC_HALF_0       3'h0
`define SCLC_HALF_2       3'h2
`define SCLC_HALF_3       3'h3
`define SCLC_HALF_4       3'h4
`define SCLC_POLY_CRC16   16'h8005
`define SCLC_POLY_CCITT   16'h1021
`define SCLC_REG_RESET    8'h00

`endif

// file: sclc_line_config.v
// Per-channel line configuration registers with indirect pointer and boundary-timed apply.
//
// Operation
// - receive control bits 7:6 give 5, 7, 6 or 8 receive data bits.
// - receive control bit 5 turns automatic CTS and DCD handshaking on.
// - receive control bit 4 puts the receiver into sync hunt mode.
// - receive control bit 3 enables receive CRC checking.
// - receive control bit 2 enables the address match search.
// - outside SDLC, receive control bit 1 passes sync characters as data, else strips.
// - in SDLC, receive control bit 1 masks address bits for multiple matches.
// - receive control bit 0 enables the receiver.
// - mode bits 7:6 select sampling divide 1, 16, 32 or 64.
// - mode bits 5:4 select 8-bit sync, 16-bit sync, SDLC flag or external sync.
// - mode bits 3:2 select synchronous, 1, 1.5 or 2 stop bits.
// - mode bit 0 enables parity; bit 1 then chooses even, else odd.
// - transmit control bit 7 drives terminal ready pin low when one.
// - transmit control bits 6:5 give 5, 7, 6 or 8 transmit data bits.
// - transmit control bit 4 sends a break on the line.
// - transmit bits: 3 enable, 2 polynomial, 1 request to send, 0 CRC generate.
// - polynomial bit one selects CRC-16, zero selects CCITT.
// - transmitter enable bit one enables the transmitter.
`timescale 1ns/1ps
`include "sclc_defs.vh"

module sclc_line_config (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        resetn,
    input  wire        chanReset,
    // CPU write port
    input  wire        cpuWrite,
    input  wire [7:0]  cpuData,
    // Character boundary status from the serial engines
    input  wire        rxCharIdle,
    input  wire        txCharIdle,
    // Modem input pins, active low
    input  wire        clearToSendN,
    input  wire        carrierDetectN,
    // Modem output pins, active low
    output wire        terminalReadyPinN,
    output wire        requestToSendPinN,
    // Receiver configuration
    output reg  [3:0]  rxCharBits,
    output reg         syncSearchMode,
    output reg         rxCheckEnable,
    output reg         stationAddressSearch,
    output reg         syncAsData,
    output reg         addressMaskMulti,
    output wire        receiverActive,
    // Line framing configuration
    output reg  [6:0]  samplingDivide,
    output reg  [1:0]  syncPatternMode,
    output reg  [2:0]  stopHalfBits,
    output reg         parityOn,
    output reg         parityEven,
    // Transmitter configuration
    output reg  [3:0]  txCharBits,
    output wire        lineBreakSend,
    output wire        transmitterActive,
    output wire [15:0] crcPolynomial,
    output wire        txCheckGenerate,
    // Register pointer status
    output wire [5:0]  regPointer
);

    reg [5:0]  pointer_reg;
    reg [7:0]  receiverControl_reg;
    reg [7:0]  receiverControl_next;
    reg [7:0]  lineModeLow_reg;
    reg [7:0]  lineModeLow_next;
    reg [7:0]  transmitterControl_reg;
    reg [7:0]  transmitterControl_next;
    reg        ctsSync1_reg;
    reg        ctsSync2_reg;
    reg        dcdSync1_reg;
    reg        dcdSync2_reg;
    reg        terminalReadyPinN_reg;
    reg        requestToSendPinN_reg;
    reg        lineBreakSend_reg;
    reg [15:0] crcPolynomial_reg;
    reg        txCheckGenerate_reg;
    reg        transmitterActive_reg;
    reg        receiverActive_reg;

    wire metaWrite;
    wire ptrWrite;
    wire auto_modem_handshake;
    wire sdlcMode;
    wire modeApply;

    // Shared by the receive and transmit width fields.
    function [3:0] charWidth;
        input [1:0] code;
        begin
            case (code)
                `SCLC_WIDTH_5: charWidth = `SCLC_BITS_5;
                `SCLC_WIDTH_7: charWidth = `SCLC_BITS_7;
                `SCLC_WIDTH_6: charWidth = `SCLC_BITS_6;
                default:       charWidth = `SCLC_BITS_8;
            endcase
        end
    endfunction

    function [6:0] divideRatio;
        input [1:0] code;
        begin
            case (code)
                `SCLC_DIV_1:  divideRatio = `SCLC_RATIO_1;
                `SCLC_DIV_16: divideRatio = `SCLC_RATIO_16;
                `SCLC_DIV_32: divideRatio = `SCLC_RATIO_32;
                default:      divideRatio = `SCLC_RATIO_64;
            endcase
        end
    endfunction

    function [2:0] stopLength;
        input [1:0] code;
        begin
            case (code)
                `SCLC_STOP_SYNC: stopLength = `SCLC_HALF_0;
                `SCLC_STOP_1:    stopLength = `SCLC_HALF_2;
                `SCLC_STOP_1P5:  stopLength = `SCLC_HALF_3;
                default:         stopLength = `SCLC_HALF_4;
            endcase
        end
    endfunction

    // A write lands in the meta register while the pointer rests at zero.
    assign metaWrite = cpuWrite && (pointer_reg == `SCLC_PTR_META);
    // Upper pointer bits set mark a channel command, not a pointer.
    assign ptrWrite  = metaWrite &&
                       (cpuData[`SCLC_PTR_CMD_HI:`SCLC_PTR_CMD_LO] == 2'h0);

    // Pointer selects the target of the following write, then falls back to meta.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pointer_reg <= `SCLC_PTR_META;
        end else if (chanReset) begin
            pointer_reg <= `SCLC_PTR_META;
        end else if (ptrWrite) begin
            pointer_reg <= cpuData[`SCLC_PTR_HI:`SCLC_PTR_LO];
        end else if (cpuWrite) begin
            pointer_reg <= `SCLC_PTR_META;
        end
    end

    // Next value of each control register; a channel reset wins over a write.
    always @* begin
        receiverControl_next    = receiverControl_reg;
        lineModeLow_next        = lineModeLow_reg;
        transmitterControl_next = transmitterControl_reg;
        if (chanReset) begin
            receiverControl_next    = `SCLC_REG_RESET;
            lineModeLow_next        = `SCLC_REG_RESET;
            transmitterControl_next = `SCLC_REG_RESET;
        end else if (cpuWrite) begin
            if (pointer_reg == `SCLC_PTR_RXCTL) begin
                receiverControl_next = cpuData;
            end
            if (pointer_reg == `SCLC_PTR_MODELO) begin
                lineModeLow_next = cpuData;
            end
            if (pointer_reg == `SCLC_PTR_TXCTL) begin
                transmitterControl_next = cpuData;
            end
        end
    end

    // Write-only control registers.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            receiverControl_reg    <= `SCLC_REG_RESET;
            lineModeLow_reg        <= `SCLC_REG_RESET;
            transmitterControl_reg <= `SCLC_REG_RESET;
        end else begin
            receiverControl_reg    <= receiverControl_next;
            lineModeLow_reg        <= lineModeLow_next;
            transmitterControl_reg <= transmitterControl_next;
        end
    end

    // Modem inputs come from pins and pass two flip-flops.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctsSync1_reg <= 1'b1;
            ctsSync2_reg <= 1'b1;
            dcdSync1_reg <= 1'b1;
            dcdSync2_reg <= 1'b1;
        end else begin
            ctsSync1_reg <= clearToSendN;
            ctsSync2_reg <= ctsSync1_reg;
            dcdSync1_reg <= carrierDetectN;
            dcdSync2_reg <= dcdSync1_reg;
        end
    end

    // Framing shared by both directions waits until neither has a character in flight.
    assign modeApply = rxCharIdle && txCharIdle;
    assign sdlcMode  = (syncPatternMode == `SCLC_SYNC_SDLC);

    // Receiver settings that shape a character follow the receive boundary.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rxCharBits           <= `SCLC_BITS_5;
            syncSearchMode       <= 1'b0;
            rxCheckEnable        <= 1'b0;
            stationAddressSearch <= 1'b0;
            syncAsData           <= 1'b0;
            addressMaskMulti     <= 1'b0;
        end else if (chanReset) begin
            rxCharBits           <= `SCLC_BITS_5;
            syncSearchMode       <= 1'b0;
            rxCheckEnable        <= 1'b0;
            stationAddressSearch <= 1'b0;
            syncAsData           <= 1'b0;
            addressMaskMulti     <= 1'b0;
        end else if (rxCharIdle) begin
            rxCharBits <= charWidth(
                receiverControl_reg[`SCLC_RX_WIDTH_HI:`SCLC_RX_WIDTH_LO]);
            syncSearchMode       <= receiverControl_reg[`SCLC_RX_HUNT];
            rxCheckEnable        <= receiverControl_reg[`SCLC_RX_CHECK];
            stationAddressSearch <= receiverControl_reg[`SCLC_RX_ADDR];
            syncAsData       <= !sdlcMode && receiverControl_reg[`SCLC_RX_MASK];
            addressMaskMulti <= sdlcMode && receiverControl_reg[`SCLC_RX_MASK];
        end
    end

    // Line framing follows the boundary of both directions.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            samplingDivide  <= `SCLC_RATIO_1;
            syncPatternMode <= 2'h0;
            stopHalfBits    <= `SCLC_HALF_0;
            parityOn        <= 1'b0;
            parityEven      <= 1'b0;
        end else if (chanReset) begin
            samplingDivide  <= `SCLC_RATIO_1;
            syncPatternMode <= 2'h0;
            stopHalfBits    <= `SCLC_HALF_0;
            parityOn        <= 1'b0;
            parityEven      <= 1'b0;
        end else if (modeApply) begin
            samplingDivide <= divideRatio(
                lineModeLow_reg[`SCLC_MD_DIV_HI:`SCLC_MD_DIV_LO]);
            syncPatternMode <= lineModeLow_reg[`SCLC_MD_SYNC_HI:`SCLC_MD_SYNC_LO];
            stopHalfBits <= stopLength(
                lineModeLow_reg[`SCLC_MD_STOP_HI:`SCLC_MD_STOP_LO]);
            parityOn   <= lineModeLow_reg[`SCLC_MD_PAR_ON];
            parityEven <= lineModeLow_reg[`SCLC_MD_EVEN];
        end
    end

    // Transmit width follows the transmit boundary.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            txCharBits <= `SCLC_BITS_5;
        end else if (chanReset) begin
            txCharBits <= `SCLC_BITS_5;
        end else if (txCharIdle) begin
            txCharBits <= charWidth(
                transmitterControl_reg[`SCLC_TX_WIDTH_HI:`SCLC_TX_WIDTH_LO]);
        end
    end

    // Auto handshake gates the transmitter on CTS and the receiver on DCD.
    assign auto_modem_handshake = receiverControl_next[`SCLC_RX_AUTO];

    // Enables, break and modem lines act at once and do not reshape a character. They load
    // from the next register value, so they change at the same edge as the register.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            terminalReadyPinN_reg <= 1'b1;
            requestToSendPinN_reg <= 1'b1;
            lineBreakSend_reg     <= 1'b0;
            crcPolynomial_reg     <= `SCLC_POLY_CCITT;
            txCheckGenerate_reg   <= 1'b0;
            transmitterActive_reg <= 1'b0;
            receiverActive_reg    <= 1'b0;
        end else begin
            terminalReadyPinN_reg <= !transmitterControl_next[`SCLC_TX_DTR];
            requestToSendPinN_reg <= !transmitterControl_next[`SCLC_TX_RTS];
            lineBreakSend_reg     <= transmitterControl_next[`SCLC_TX_BREAK];
            crcPolynomial_reg     <= transmitterControl_next[`SCLC_TX_POLY] ?
                                     `SCLC_POLY_CRC16 : `SCLC_POLY_CCITT;
            txCheckGenerate_reg   <= transmitterControl_next[`SCLC_TX_CHECK];
            transmitterActive_reg <= transmitterControl_next[`SCLC_TX_ON] &&
                                     (!auto_modem_handshake || !ctsSync2_reg);
            receiverActive_reg    <= receiverControl_next[`SCLC_RX_ON] &&
                                     (!auto_modem_handshake || !dcdSync2_reg);
        end
    end

    assign terminalReadyPinN = terminalReadyPinN_reg;
    assign requestToSendPinN = requestToSendPinN_reg;
    assign lineBreakSend     = lineBreakSend_reg;
    assign crcPolynomial     = crcPolynomial_reg;
    assign txCheckGenerate   = txCheckGenerate_reg;
    assign transmitterActive = transmitterActive_reg;
    assign receiverActive    = receiverActive_reg;
    assign regPointer        = pointer_reg;

endmodule // sclc_line_config

// file: sclc_line_config_chk.sv
// Assertion checker for the serial channel line configuration block.
`timescale 1ns/1ps
module sclc_line_config_chk (
    // Clock and reset
    input wire        sys_clk,
    input wire        resetn,
    input wire        chanReset,
    // CPU side and character status
    input wire        cpuWrite,
    input wire [7:0]  cpuData,
    input wire        rxCharIdle,
    input wire        txCharIdle,
    // Watched outputs
    input wire        terminalReadyPinN,
    input wire        requestToSendPinN,
    input wire        lineBreakSend,
    input wire [15:0] crcPolynomial,
    input wire        txCheckGenerate,
    input wire [5:0]  regPointer,
    input wire [3:0]  rxCharBits,
    input wire [3:0]  txCharBits
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    wire wrAny = cpuWrite && !chanReset;
    wire wrTx  = wrAny && regPointer == 6'h05;

    chk_dtr_pin: assert property (wrTx |=> terminalReadyPinN == !$past(cpuData[7]))
        else $error("terminal ready pin wrong");
    chk_rts_pin: assert property (wrTx |=> requestToSendPinN == !$past(cpuData[1]))
        else $error("request to send pin wrong");
    chk_break_bit: assert property (wrTx |=> lineBreakSend == $past(cpuData[4]))
        else $error("break output wrong");
    chk_poly_pick: assert property (wrTx |=>
        crcPolynomial == ($past(cpuData[2]) ? 16'h8005 : 16'h1021))
        else $error("polynomial wrong");
    chk_crc_gen: assert property (wrTx |=> txCheckGenerate == $past(cpuData[0]))
        else $error("crc generate wrong");
    chk_ptr_load: assert property (wrAny && regPointer == 6'h00 &&
        cpuData[5:4] == 2'h0 |=> regPointer == $past(cpuData[5:0]))
        else $error("pointer not loaded");
    chk_ptr_back: assert property (wrAny && regPointer != 6'h00 |=> regPointer == 6'h00)
        else $error("pointer not cleared");
    chk_rx_hold: assert property (!rxCharIdle && !chanReset |=> $stable(rxCharBits))
        else $error("rx width changed mid character");
    chk_tx_hold: assert property (!txCharIdle && !chanReset |=> $stable(txCharBits))
        else $error("tx width changed mid character");

    cover property (wrTx);
    cover property (wrAny && regPointer == 6'h03);
    cover property (!rxCharIdle && wrAny);
endmodule // sclc_line_config_chk

bind sclc_line_config sclc_line_config_chk chk (.*);

// file: sclc_modem_model.sv
// Modem partner that answers request to send and raises carrier detect.
`timescale 1ns/1ps
module sclc_modem_model (
    // Clock and behaviour control
    input  wire sys_clk,
    input  wire slowAnswer,
    input  wire carrierUp,
    // Modem pins
    input  wire requestToSendPinN,
    input  wire terminalReadyPinN,
    output reg  clearToSendN,
    output reg  carrierDetectN
);
    reg [3:0] waitCnt;
    initial begin
        clearToSendN = 1'b1;
        carrierDetectN = 1'b1;
        waitCnt = 4'h0;
    end
    // Carrier only with terminal ready; clear to send after two or nine cycles.
    always @(posedge sys_clk) begin
        carrierDetectN <= !(carrierUp && !terminalReadyPinN);
        if (requestToSendPinN) begin
            waitCnt <= 4'h0;
            clearToSendN <= 1'b1;
        end else if (waitCnt == (slowAnswer ? 4'h8 : 4'h1))
            clearToSendN <= 1'b0;
        else
            waitCnt <= waitCnt + 4'h1;
    end
endmodule // sclc_modem_model

// file: sclc_line_config_tb_top.sv
// Self-checking testbench for the serial channel line configuration block.
`timescale 1ns/1ps
module sclc_line_config_tb_top;
    // Driven
    reg         sys_clk, resetn, chanReset, cpuWrite, rxCharIdle, txCharIdle;
    reg         slowAnswer, carrierUp;
    reg  [7:0]  cpuData, d;
    // Observed
    wire        clearToSendN, carrierDetectN, terminalReadyPinN, requestToSendPinN;
    wire        syncSearchMode, rxCheckEnable, stationAddressSearch, syncAsData;
    wire        addressMaskMulti, receiverActive, parityOn, parityEven;
    wire        lineBreakSend, transmitterActive, txCheckGenerate;
    wire [3:0]  rxCharBits, txCharBits;
    wire [6:0]  samplingDivide;
    wire [2:0]  stopHalfBits;
    wire [1:0]  syncPatternMode;
    wire [15:0] crcPolynomial;
    wire [5:0]  regPointer;
    integer     err_total, checked, c;
    localparam [15:0] WID = 16'h8675;
    localparam [31:0] DIV = 32'h40201001;
    localparam [15:0] STP = 16'h4320;

    sclc_line_config dut (.*);
    sclc_modem_model modem (.*);

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task chk(input string nm, input [15:0] got, input [15:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("ERROR %0s expected %h seen %h", nm, exp, got);
        end
    endtask

    task wr1(input [7:0] v);
        @(posedge sys_clk);
        cpuWrite <= 1'b1;
        cpuData <= v;
        @(posedge sys_clk);
        cpuWrite <= 1'b0;
    endtask

    // Pointer write and data write back to back, then let outputs and modem settle.
    task wr(input [5:0] p, input [7:0] v);
        @(posedge sys_clk);
        cpuWrite <= 1'b1;
        cpuData <= {2'h0, p};
        @(posedge sys_clk);
        cpuData <= v;
        @(posedge sys_clk);
        cpuWrite <= 1'b0;
        repeat (14) @(negedge sys_clk);
    endtask

    task t_rx;
        for (c = 0; c < 4; c = c + 1) begin
            d = {c[1:0], c[0] ? 6'h3d : 6'h03};
            wr(6'h03, d);
            chk("rxBits", rxCharBits, WID[4*c +: 4]);
            chk("hunt", syncSearchMode, d[4]);
            chk("rxCheck", rxCheckEnable, d[3]);
            chk("addrSearch", stationAddressSearch, d[2]);
            chk("syncData", syncAsData, d[1]);
            chk("rxActive", receiverActive, !d[5]);
        end
        $display("test rx done");
    endtask

    task t_mode;
        for (c = 0; c < 4; c = c + 1) begin
            d = {c[1:0], c[1:0], c[1:0], c[0], c[1]};
            wr(6'h04, d);
            chk("divide", samplingDivide, DIV[8*c +: 7]);
            chk("syncMode", syncPatternMode, c[1:0]);
            chk("stop", stopHalfBits, STP[4*c +: 3]);
            chk("parOn", parityOn, d[0]);
            chk("parEven", parityEven, d[1]);
        end
        wr(6'h04, 8'h20);
        wr(6'h03, 8'h02);
        chk("maskMulti", addressMaskMulti, 1'b1);
        chk("syncData", syncAsData, 1'b0);
        $display("test mode done");
    endtask

    task t_tx;
        wr(6'h03, 8'he1);
        carrierUp = 1'b1;
        for (c = 0; c < 4; c = c + 1) begin
            slowAnswer = c[0];
            d = {c[0], c[1:0], c[1], 1'b1, c[0], c[1], c[0]};
            wr(6'h05, d);
            chk("txBits", txCharBits, WID[4*c +: 4]);
            chk("dtrPin", terminalReadyPinN, !d[7]);
            chk("rtsPin", requestToSendPinN, !d[1]);
            chk("break", lineBreakSend, d[4]);
            chk("poly", crcPolynomial, d[2] ? 16'h8005 : 16'h1021);
            chk("crcGen", txCheckGenerate, d[0]);
            chk("txActive", transmitterActive, d[1]);
            chk("rxActive", receiverActive, d[7]);
        end
        wr(6'h05, 8'h02);
        chk("txOff", transmitterActive, 1'b0);
        $display("test tx done");
    endtask

    task t_edge;
        @(posedge sys_clk);
        rxCharIdle <= 1'b0;
        txCharIdle <= 1'b0;
        wr(6'h03, 8'h00);
        wr(6'h05, 8'h60);
        wr(6'h04, 8'hc0);
        chk("rxHeld", rxCharBits, 4'h8);
        chk("txHeld", txCharBits, 4'h5);
        @(posedge sys_clk);
        rxCharIdle <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk("rxNew", rxCharBits, 4'h5);
        chk("divHeld", samplingDivide, 7'h01);
        @(posedge sys_clk);
        txCharIdle <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk("txNew", txCharBits, 4'h8);
        chk("divNew", samplingDivide, 7'h40);
        $display("test boundary done");
    endtask

    task t_refuse;
        wr(6'h07, 8'hff);
        chk("ptrBack", regPointer, 6'h00);
        chk("txKept", txCharBits, 4'h8);
        wr1(8'h15);
        @(negedge sys_clk);
        chk("ptrResetB", regPointer, 6'h00);
        wr1(8'h05);
        @(posedge sys_clk);
        chanReset <= 1'b1;
        @(posedge sys_clk);
        chanReset <= 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("ptrClr", regPointer, 6'h00);
        chk("txClr", txCharBits, 4'h5);
        $display("test refuse done");
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        resetn = 1'b0;
        chanReset = 1'b0;
        cpuWrite = 1'b0;
        cpuData = 8'h00;
        rxCharIdle = 1'b1;
        txCharIdle = 1'b1;
        slowAnswer = 1'b0;
        carrierUp = 1'b0;
        err_total = 0;
        checked = 0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        chk("rstDiv", samplingDivide, 7'h01);
        chk("rstDtr", terminalReadyPinN, 1'b1);
        t_rx;
        t_mode;
        t_tx;
        t_edge;
        t_refuse;
        test_done;
    end

    initial begin
        #1000000;
        err_total = err_total + 1;
        test_done;
    end
endmodule // sclc_line_config_tb_top
